// File: core/link_edge_sync.sv
// Synchroniser for one bus clock pin and its companion signals.
// Assumes the bus clock is much slower than i_clk (at least 4x).

`timescale 1ns/10ps
`default_nettype none

module link_edge_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_arst_n,
	// Pins
	input  wire logic          i_link_clk,
	input  wire logic [W-1:0]  i_data,
	// Synchronised view
	output logic               o_rise,
	output logic               o_fall,
	output logic [W-1:0]       o_data
);

	logic [1:0]    clk_sync;
	logic          clk_last;
	logic [W-1:0]  data_meta;
	logic [W-1:0]  data_sync;

	// Two stages on every pin, third stage for edges
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			clk_sync  <= 2'h0;
			clk_last  <= 1'b0;
			data_meta <= '0;
			data_sync <= '0;
		end else begin
			clk_sync  <= {clk_sync[0], i_link_clk};
			clk_last  <= clk_sync[1];
			data_meta <= i_data;
			data_sync <= data_meta;
		end
	end

	// Edge pulses from the second and third stages
	assign o_rise = clk_sync[1] & ~clk_last;
	assign o_fall = ~clk_sync[1] & clk_last;
	assign o_data = data_sync;

endmodule // link_edge_sync

`default_nettype wire

// File: core/tbus_b_port.sv
// B drop/add telecom bus port: drop sampling with parity check,
// add slot insertion with selectable timing source.
// Assumes bus pins change well clear of the sampling edges.
//
// Contract
// (R1) Partner runs bus clock at 19.44 MHz or 6.48 MHz per bus rate.
// (R2) Drop data, parity, payload flag, marker sampled on drop clock fall.
// (R3) Timing select high: add timing comes from drop clock and framing.
// (R4) Drop timing: add outputs change on drop clock rise, selected slot only.
// (R5) Default drop parity odd over data, payload flag and marker; checked.
// (R6) Config selects even drop parity and data-only checking independently.
// (R7) Bit 7 carries the first transmitted bit on drop and add bytes.
// (R8) Partner holds payload flag high through payload bytes, low otherwise.
// (R9) Marker pulses at the first C1 byte position of each frame.
// (R10) Marker carries one-clock J1 pulses: one or three per frame.
// (R11) V1 pulses on the drop marker are ignored; with timing select high they reset mf_phase and pulse o_mframe_start.
// (R12) Timing select low: partner supplies add clock, flag and marker.
// (R13) Add timing: add flag and marker sampled on add clock fall.
// (R14) Add timing: add outputs change on add clock rise, in slot only.
// (R15) Timing select high: add clock input is ignored completely.
// (R16) Add parity odd over add data by default, even by config.
// (R17) Add parity driven only while adding data, else released.
// (R18) Add data driven only in selected slots, else released.
// (R19) V1 pulses on the add marker mark the tributary multiframe.
// (R20) Add-present asserted exactly in slots; active low unless configured.
// (R21) Failed drop parity sets a sticky error flag for software.
//
// Strobed register access and the register offsets are this design's own decisions.

`timescale 1ns/10ps
`default_nettype none

module tbus_b_port #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	// Register port
	input  wire logic [3:0]  i_reg_addr,
	input  wire logic [15:0] i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic [15:0]      o_reg_rdata,
	// Drop bus pins
	input  wire logic        i_drop_bus_clock,
	input  wire logic [7:0]  i_drop_data_byte,
	input  wire logic        i_drop_parity_in,
	input  wire logic        i_drop_payload_flag,
	input  wire logic        i_drop_frame_marker,
	// Add bus pins
	input  wire logic        i_add_timing_select,
	input  wire logic        i_add_bus_clock,
	input  wire logic        i_add_payload_flag,
	input  wire logic        i_add_frame_marker,
	output logic [7:0]       o_add_data_byte,
	output logic             o_add_data_oe,
	output logic             o_add_parity_out,
	output logic             o_add_parity_oe,
	output logic             o_add_present_flag,
	// Dropped stream
	output logic [7:0]       o_drop_byte,
	output logic             o_drop_valid,
	output logic             o_drop_spe,
	output logic             o_drop_c1,
	output logic             o_drop_j1,
	output logic             o_drop_parity_err,
	// Tributary source
	input  wire logic [7:0]  i_trib_byte,
	output logic             o_trib_take,
	output logic             o_mframe_start
);

	// ****************************************
	// Elaboration check
	// ****************************************
	if (CNT_W < 2 || CNT_W > tbus_pkg::DATA_W) begin : g_bad_cnt
		$error("CNT_W must lie between 2 and the register width");
	end

	// Classify a marker pulse by payload flag and J1 count
	function automatic tbus_pkg::mark_t classify(
		input logic       mark,
		input logic       spe,
		input logic [1:0] j1_cnt,
		input logic [1:0] j1_max
	);
		if (!mark)
			return tbus_pkg::MARK_NONE;
		else if (!spe)
			return tbus_pkg::MARK_C1;
		else if (j1_cnt < j1_max)
			return tbus_pkg::MARK_J1;
		else
			return tbus_pkg::MARK_V1;
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic        d_rise;
	logic        d_fall;
	logic [10:0] d_pins;
	logic        a_rise;
	logic        a_fall;
	logic [2:0]  a_pins;

	// (R2) Drop pins sampled together
	link_edge_sync #(.W(11)) u_drop_sync (
		.i_clk      (i_clk),
		.i_arst_n   (i_arst_n),
		.i_link_clk (i_drop_bus_clock),
		.i_data     ({i_drop_data_byte, i_drop_parity_in,
		              i_drop_payload_flag, i_drop_frame_marker}),
		.o_rise     (d_rise),
		.o_fall     (d_fall),
		.o_data     (d_pins)
	);

	link_edge_sync #(.W(3)) u_add_sync (
		.i_clk      (i_clk),
		.i_arst_n   (i_arst_n),
		.i_link_clk (i_add_bus_clock),
		.i_data     ({i_add_timing_select, i_add_payload_flag,
		              i_add_frame_marker}),
		.o_rise     (a_rise),
		.o_fall     (a_fall),
		.o_data     (a_pins)
	);

	// ****************************************
	// Registers
	// ****************************************
	logic [4:0]        ctrl;
	logic [7:0]        slot_ofs;
	logic [7:0]        slot_per;
	logic              par_err;
	logic [CNT_W-1:0]  err_cnt;
	logic [1:0]        mf_phase;
	tbus_pkg::tstate_t tstate;

	// Address decode
	wire wr_ctrl   = i_reg_wr && (i_reg_addr == tbus_pkg::REG_CTRL);
	wire wr_slot   = i_reg_wr && (i_reg_addr == tbus_pkg::REG_SLOT);
	wire wr_status = i_reg_wr && (i_reg_addr == tbus_pkg::REG_STATUS);
	wire clr_err   = wr_status && i_reg_wdata[tbus_pkg::STAT_PAR_ERR];

	wire [15:0] stat_word = {11'h000, (tstate == tbus_pkg::T_FRAMED),
		mf_phase, a_pins[2], par_err};
	wire [15:0] rd_word =
		(i_reg_addr == tbus_pkg::REG_CTRL)   ? {11'h000, ctrl} :
		(i_reg_addr == tbus_pkg::REG_SLOT)   ? {slot_per, slot_ofs} :
		(i_reg_addr == tbus_pkg::REG_STATUS) ? stat_word :
		(i_reg_addr == tbus_pkg::REG_ERRCNT) ?
			16'(err_cnt) : 16'h0000;

	// Config writes and one-cycle read data
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl        <= tbus_pkg::CTRL_RESET;
			slot_ofs    <= tbus_pkg::SLOT_OFS_RESET;
			slot_per    <= tbus_pkg::SLOT_PER_RESET;
			o_reg_rdata <= 16'h0000;
		end else begin
			if (wr_ctrl)
				ctrl <= i_reg_wdata[4:0];
			if (wr_slot) begin
				slot_ofs <= i_reg_wdata[tbus_pkg::SLOT_OFS_LSB +: 8];
				slot_per <= i_reg_wdata[tbus_pkg::SLOT_PER_LSB +: 8];
			end
			o_reg_rdata <= i_reg_rd ? rd_word : 16'h0000;
		end
	end

	wire [1:0] j1_max = ctrl[tbus_pkg::CTRL_THREE_J1] ?
		tbus_pkg::J1_THREE : tbus_pkg::J1_ONE;

	// ****************************************
	// Drop side
	// ****************************************
	wire [7:0] d_byte = d_pins[10:3];
	wire       d_par  = d_pins[2];
	wire       d_spe  = d_pins[1];
	wire       d_mark = d_pins[0];
	logic [1:0] d_j1_cnt;

	// (R5) Parity sum over data, flag and marker
	// (R6) Data-only and even options
	wire d_sum = (^d_byte) ^ d_par ^
		(ctrl[tbus_pkg::CTRL_DATA_ONLY] ? 1'b0 : (d_spe ^ d_mark));
	wire d_bad = d_sum == ctrl[tbus_pkg::CTRL_DROP_EVEN];
	wire d_err = d_fall && d_bad;
	tbus_pkg::mark_t d_kind;
	assign d_kind = classify(d_mark, d_spe, d_j1_cnt, j1_max);

	// Dropped byte capture on drop clock fall
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_drop_byte  <= 8'h00;
			o_drop_valid <= 1'b0;
			o_drop_spe   <= 1'b0;
			o_drop_c1    <= 1'b0;
			o_drop_j1    <= 1'b0;
			d_j1_cnt     <= 2'h0;
		end else begin
			o_drop_valid <= d_fall;
			o_drop_c1    <= d_fall && (d_kind == tbus_pkg::MARK_C1);
			// (R11) V1 pulses give no output
			o_drop_j1    <= d_fall && (d_kind == tbus_pkg::MARK_J1);
			if (d_fall) begin
				// (R7) Bit 7 first, passed unchanged
				o_drop_byte <= d_byte;
				o_drop_spe  <= d_spe;
				if (d_kind == tbus_pkg::MARK_C1)
					d_j1_cnt <= 2'h0;
				else if (d_kind == tbus_pkg::MARK_J1)
					d_j1_cnt <= 2'(d_j1_cnt + 2'h1);
			end
		end
	end

	// (R21) Sticky error, set wins over clear
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			par_err           <= 1'b0;
			err_cnt           <= '0;
			o_drop_parity_err <= 1'b0;
		end else begin
			par_err           <= d_err | (par_err & ~clr_err);
			o_drop_parity_err <= d_err | (par_err & ~clr_err);
			if (d_err)
				err_cnt <= CNT_W'(err_cnt + 1'b1);
		end
	end

	// ****************************************
	// Add timing source
	// ****************************************
	// (R3) Select high: drop clock and framing
	// (R15) Add clock edges unused then
	wire sel    = a_pins[2];
	wire t_fall = sel ? d_fall : a_fall;
	wire t_rise = sel ? d_rise : a_rise;
	// (R13) Add flag and marker at add clock fall
	wire t_spe  = sel ? d_spe  : a_pins[1];
	wire t_mark = sel ? d_mark : a_pins[0];

	logic [1:0] t_j1_cnt;
	logic [7:0] slot_pos;
	logic       slot_hit;
	tbus_pkg::mark_t t_kind;
	assign t_kind = classify(t_mark, t_spe, t_j1_cnt, j1_max);

	// Payload byte position since the last J1, wrapping to 0 at slot_per
	wire [7:0] pos_inc  = (slot_pos + 8'h01 >= slot_per) ?
		8'h00 : 8'(slot_pos + 8'h01);
	wire [7:0] pos_now  = (t_kind == tbus_pkg::MARK_J1) ? 8'h00 : pos_inc;
	wire       hit_now  = (tstate == tbus_pkg::T_FRAMED) && t_spe &&
		(pos_now == slot_ofs);

	// Framing, slot and multiframe tracking on timing fall
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tstate         <= tbus_pkg::T_HUNT;
			t_j1_cnt       <= 2'h0;
			slot_pos       <= 8'h00;
			slot_hit       <= 1'b0;
			mf_phase       <= 2'h0;
			o_mframe_start <= 1'b0;
		end else begin
			o_mframe_start <= t_fall && (t_kind == tbus_pkg::MARK_V1);
			if (t_fall) begin
				slot_hit <= hit_now;
				if (t_spe)
					slot_pos <= pos_now;
				case (t_kind)
					tbus_pkg::MARK_C1: begin
						tstate   <= tbus_pkg::T_FRAMED;
						t_j1_cnt <= 2'h0;
						mf_phase <= 2'(mf_phase + 2'h1);
					end
					tbus_pkg::MARK_J1: begin
						t_j1_cnt <= 2'(t_j1_cnt + 2'h1);
					end
					// (R19) V1 restarts multiframe phase
					tbus_pkg::MARK_V1: begin
						mf_phase <= 2'h0;
					end
					default: begin
						tstate <= tstate;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Add outputs
	// ****************************************
	// (R16) Odd or even add parity
	wire add_par  = (^i_trib_byte) ^ ~ctrl[tbus_pkg::CTRL_ADD_EVEN];
	wire pres_act = ctrl[tbus_pkg::CTRL_PRES_HIGH];

	// (R4) (R14) Outputs change on timing rise
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_add_data_byte  <= 8'h00;
			o_add_data_oe    <= 1'b0;
			o_add_parity_out <= 1'b0;
			o_add_parity_oe  <= 1'b0;
			o_trib_take      <= 1'b0;
		end else begin
			o_trib_take <= t_rise && slot_hit;
			if (t_rise) begin
				// (R18) Data driven in slot only
				// (R7) Bit 7 leaves first
				o_add_data_oe    <= slot_hit;
				o_add_data_byte  <= slot_hit ? i_trib_byte : 8'h00;
				// (R17) Parity driven with data only
				o_add_parity_oe  <= slot_hit;
				o_add_parity_out <= slot_hit ? add_par : 1'b0;
			end
		end
	end

	// (R20) Present flag follows slot, polarity selectable
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_add_present_flag <= 1'b1;
		else if (t_rise)
			o_add_present_flag <= slot_hit ? pres_act : ~pres_act;
		else if (!o_add_data_oe)
			o_add_present_flag <= ~pres_act;
	end

endmodule // tbus_b_port

`default_nettype wire

// File: core/tbus_pkg.sv
// Constants, field layout and marker kinds of the B telecom bus port.
// Assumes one system clock; all bus pins are asynchronous to it.

package tbus_pkg;

	// ****************************************
	// Register port
	// ****************************************
	localparam int          ADDR_W     = 4;
	localparam int          DATA_W     = 16;
	localparam logic [3:0]  REG_CTRL   = 4'h0;
	localparam logic [3:0]  REG_SLOT   = 4'h1;
	localparam logic [3:0]  REG_STATUS = 4'h2;
	localparam logic [3:0]  REG_ERRCNT = 4'h3;

	// ****************************************
	// Control fields
	// ****************************************
	localparam int          CTRL_W          = 5;
	localparam int          CTRL_DROP_EVEN  = 0;
	localparam int          CTRL_DATA_ONLY  = 1;
	localparam int          CTRL_ADD_EVEN   = 2;
	localparam int          CTRL_PRES_HIGH  = 3;
	localparam int          CTRL_THREE_J1   = 4;
	localparam logic [4:0]  CTRL_RESET      = 5'h00;

	// ****************************************
	// Slot fields: offset low byte, period high byte
	// ****************************************
	localparam int          SLOT_OFS_LSB     = 0;
	localparam int          SLOT_PER_LSB     = 8;
	localparam logic [7:0]  SLOT_OFS_RESET   = 8'h00;
	localparam logic [7:0]  SLOT_PER_RESET   = 8'h1c;

	// ****************************************
	// Status fields
	// ****************************************
	localparam int          STAT_PAR_ERR   = 0;
	localparam int          STAT_SEL       = 1;
	localparam int          STAT_MF_LSB    = 2;
	localparam int          STAT_FRAMED    = 4;

	// ****************************************
	// Bus rates and J1 counts
	// ****************************************
	localparam int          BUS_CLK_STS3_KHZ = 19440;
	localparam int          BUS_CLK_STS1_KHZ = 6480;
	localparam logic [1:0]  J1_ONE           = 2'h1;
	localparam logic [1:0]  J1_THREE         = 2'h3;

	// Frame marker pulse kinds
	typedef enum logic [1:0] {MARK_NONE, MARK_C1, MARK_J1, MARK_V1} mark_t;

	// Add timing states
	typedef enum logic {T_HUNT, T_FRAMED} tstate_t;

endpackage

// File: tb/bus_feed.sv
// Model of the terminator driving one bus clock, byte and framing.
// Assumes the bench loads the next byte before each partner rise.
`timescale 1ns/10ps
`default_nettype none
module bus_feed #(
	parameter int PH = 0
) (
	// Bench side
	input  wire logic       i_run,
	input  wire logic [7:0] i_byte,
	input  wire logic       i_spe,
	input  wire logic       i_mark,
	input  wire logic       i_flip,
	// Bus pins
	output logic            o_clk,
	output logic [7:0]      o_byte,
	output logic            o_par,
	output logic            o_spe,
	output logic            o_mark
);
	// ****************************************
	// Bus clock, 800 ns, still between frames
	// ****************************************
	// Clock from partner
	initial begin
		{o_clk, o_byte, o_par, o_spe, o_mark} = 12'h000;
		#PH;
		forever begin
			#400;
			if (i_run || o_clk)
				o_clk = ~o_clk;
		end
	end
	// Odd parity over byte, flag, marker
	always @(posedge o_clk) begin
		o_byte <= i_byte;
		o_spe <= i_spe;
		o_mark <= i_mark;
		o_par <= ~^{i_byte, i_spe, i_mark} ^ i_flip;
	end
endmodule // bus_feed
`default_nettype wire

// File: tb/tbus_b_monitor.sv
// Checker on the B bus port outputs.
// Assumes CTRL is only written while the add bus idles.
`timescale 1ns/10ps
`default_nettype none
module tbus_b_monitor (
	// Clock, reset, register port
	input wire logic        i_clk,
	input wire logic        i_arst_n,
	input wire logic [3:0]  i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic        i_reg_wr,
	input wire logic [7:0]  i_trib_byte,
	// Watched outputs
	input wire logic        o_add_data_oe,
	input wire logic [7:0]  o_add_data_byte,
	input wire logic        o_add_parity_out,
	input wire logic        o_add_parity_oe,
	input wire logic        o_add_present_flag,
	input wire logic        o_drop_valid,
	input wire logic        o_drop_spe,
	input wire logic        o_drop_c1,
	input wire logic        o_drop_j1,
	input wire logic        o_drop_parity_err,
	input wire logic        o_trib_take
);
	// ****************************************
	// Control mirror and sequences
	// ****************************************
	logic [4:0] ctrl;
	wire        clr = i_reg_wr && i_reg_addr == 4'h2 && i_reg_wdata[0];
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			ctrl <= 5'h00;
		else if (i_reg_wr && i_reg_addr == 4'h0)
			ctrl <= i_reg_wdata[4:0];
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_quiet;
		!o_drop_valid [*3];
	endsequence
	sequence s_take;
		o_trib_take && o_add_data_oe;
	endsequence
	// ****************************************
	// Assertions
	// ****************************************
	AST_PAR_OE: assert property (o_add_parity_oe == o_add_data_oe)
		else $error("parity enable differs from data enable");
	AST_DATA_OFF: assert property (!o_add_data_oe |-> !o_add_data_byte)
		else $error("add data not idle");
	AST_TAKE: assert property (o_trib_take |-> s_take ##1 !o_trib_take)
		else $error("bad tributary take");
	AST_TAKE_DATA: assert property (o_trib_take |->
		o_add_data_byte == $past(i_trib_byte)
		&& o_add_parity_out == (^o_add_data_byte ^ !ctrl[2]))
		else $error("add byte or parity wrong");
	AST_PRES_ON: assert property (s_take |-> o_add_present_flag == ctrl[3])
		else $error("present flag inactive in slot");
	AST_PRES_OFF: assert property ($fell(o_add_data_oe) |->
		o_add_present_flag == !ctrl[3])
		else $error("present flag active out of slot");
	AST_VALID: assert property (o_drop_valid |=> s_quiet)
		else $error("drop strobes too close");
	AST_MARK: assert property ((o_drop_c1 || o_drop_j1) |-> o_drop_valid
		&& (o_drop_c1 ? !o_drop_spe : o_drop_spe))
		else $error("marker kind wrong");
	AST_ERR_SET: assert property ($rose(o_drop_parity_err) |-> o_drop_valid)
		else $error("error flag without byte");
	AST_ERR_HOLD: assert property (o_drop_parity_err && !clr && !$past(clr)
		|=> o_drop_parity_err)
		else $error("error flag dropped");
endmodule // tbus_b_monitor
bind tbus_b_port tbus_b_monitor u_tbus_b_monitor (
	.i_clk, .i_arst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_trib_byte,
	.o_add_data_oe, .o_add_data_byte, .o_add_parity_out, .o_add_parity_oe,
	.o_add_present_flag, .o_drop_valid, .o_drop_spe, .o_drop_c1,
	.o_drop_j1, .o_drop_parity_err, .o_trib_take
);
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the B telecom bus port.
// Assumes bus_feed and the checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	// ****************************************
	// Signals
	// ****************************************
	logic        i_clk = 1'b0;
	logic        i_arst_n, i_reg_wr, i_reg_rd, i_add_timing_select;
	logic [3:0]  i_reg_addr;
	logic [15:0] i_reg_wdata, o_reg_rdata;
	logic [7:0]  i_trib_byte, o_add_data_byte, o_drop_byte;
	logic [7:0]  i_drop_data_byte, dbyte;
	logic        i_drop_bus_clock, i_drop_parity_in, i_drop_payload_flag;
	logic        i_drop_frame_marker, i_add_bus_clock, i_add_payload_flag;
	logic        i_add_frame_marker, o_add_data_oe, o_add_parity_out;
	logic        o_add_parity_oe, o_add_present_flag, o_drop_valid;
	logic        o_drop_spe, o_drop_c1, o_drop_j1, o_drop_parity_err;
	logic        o_trib_take, o_mframe_start;
	logic        drun, dspe, dmark, dflip, arun, aspe, amark;
	logic [4:0]  cfg;
	logic [10:0] exp_q[$];
	int          mismatches, samples_checked, takes, mfs, cycles;

	tbus_b_port u_tbus_b_port (
		.i_clk, .i_arst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
		.o_reg_rdata, .i_drop_bus_clock, .i_drop_data_byte, .i_drop_parity_in,
		.i_drop_payload_flag, .i_drop_frame_marker, .i_add_timing_select,
		.i_add_bus_clock, .i_add_payload_flag, .i_add_frame_marker,
		.o_add_data_byte, .o_add_data_oe, .o_add_parity_out, .o_add_parity_oe,
		.o_add_present_flag, .o_drop_byte, .o_drop_valid, .o_drop_spe,
		.o_drop_c1, .o_drop_j1, .o_drop_parity_err, .i_trib_byte,
		.o_trib_take, .o_mframe_start
	);
	bus_feed u_bus_feed_drop (
		.i_run(drun), .i_byte(dbyte), .i_spe(dspe), .i_mark(dmark),
		.i_flip(dflip), .o_clk(i_drop_bus_clock), .o_byte(i_drop_data_byte),
		.o_par(i_drop_parity_in), .o_spe(i_drop_payload_flag),
		.o_mark(i_drop_frame_marker)
	);
	bus_feed #(.PH(170)) u_bus_feed_add (
		.i_run(arun), .i_byte(8'h00), .i_spe(aspe), .i_mark(amark),
		.i_flip(1'b0), .o_clk(i_add_bus_clock), .o_byte(), .o_par(),
		.o_spe(i_add_payload_flag), .o_mark(i_add_frame_marker)
	);
	// ****************************************
	// Clock, watchdog, output scoreboard
	// ****************************************
	initial begin
		forever #50 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 5000) begin
			check(1'b0, "timeout");
			report_and_stop();
		end
	end
	always @(negedge i_clk) begin
		if (o_drop_valid === 1'b1)
			check(exp_q.size() > 0 && {o_drop_byte, o_drop_spe, o_drop_c1,
				o_drop_j1} === exp_q.pop_front(), "drop byte");
		if (o_trib_take === 1'b1) begin
			takes++;
			check(o_add_data_oe === 1'b1 && o_add_data_byte === i_trib_byte
				&& o_add_parity_out === (^i_trib_byte ^ ~cfg[2])
				&& o_add_present_flag === cfg[3], "add slot outputs");
		end
		if (o_mframe_start === 1'b1)
			mfs++;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		if (a == 4'h0)
			cfg = d[4:0];
		@(posedge i_clk);
		{i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'b1};
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge i_clk);
		{i_reg_addr, i_reg_rd} <= {a, 1'b1};
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		@(negedge i_clk);
		check(o_reg_rdata === e, "register read");
	endtask
	task automatic send(input bit a, input logic [7:0] d,
		input logic s, m, f, input logic [1:0] cj);
		@(posedge i_clk);
		if (a) begin
			{aspe, amark, arun} <= {s, m, 1'b1};
			@(posedge i_add_bus_clock);
		end else begin
			{dbyte, dspe, dmark, dflip, drun} <= {d, s, m, f, 1'b1};
			exp_q.push_back({d, s, cj});
			@(posedge i_drop_bus_clock);
		end
	endtask
	task automatic idle;
		@(posedge i_clk);
		{drun, arun} <= 2'b00;
		repeat (16) @(posedge i_clk);
	endtask
	task automatic frame(input bit a);
		send(a, 8'h80, 1'b0, 1'b1, 1'b0, 2'b10);
		send(a, 8'h41, 1'b1, 1'b1, 1'b0, 2'b01);
		for (int i = 0; i < 5; i++)
			send(a, 8'(8'h13 * i + 1), 1'b1, 1'b0, 1'b0, 2'b00);
	endtask
	task automatic drop_parity;
		frame(1'b0);
		send(1'b0, 8'h7e, 1'b1, 1'b1, 1'b0, 2'b00);
		send(1'b0, 8'h01, 1'b1, 1'b0, 1'b1, 2'b00);
		idle();
		rd(4'h2, 16'h0013);
		wr(4'h2, 16'h0001);
		wr(4'h0, 16'h0013);
		check(o_drop_parity_err === 1'b0, "error not cleared");
		send(1'b0, 8'hc3, 1'b0, 1'b1, 1'b0, 2'b10);
		for (int i = 0; i < 4; i++)
			send(1'b0, 8'(i), 1'b1, 1'b1, 1'b1, (i < 3) ? 2'b01 : 2'b00);
		send(1'b0, 8'h5a, 1'b0, 1'b0, 1'b1, 2'b00);
		idle();
		check(o_drop_parity_err === 1'b0, "false parity error");
		send(1'b0, 8'h5a, 1'b0, 1'b0, 1'b0, 2'b00);
		idle();
		check(o_drop_parity_err === 1'b1, "parity error missed");
		wr(4'h2, 16'h0001);
		wr(4'h0, 16'h0000);
	endtask
	task automatic add_drop_timed;
		takes = 0;
		wr(4'h1, 16'h0301);
		@(posedge i_clk);
		{aspe, amark, arun} <= 3'b111;
		frame(1'b0);
		// Trailing byte lets the last slot end
		send(1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 2'b00);
		idle();
		check(takes == 2 && o_add_data_oe === 1'b0, "drop timed slots");
	endtask
	task automatic add_own_timed;
		{takes, mfs} = 0;
		wr(4'h0, 16'h000c);
		@(posedge i_clk);
		{i_add_timing_select, i_trib_byte} <= {1'b0, 8'hc6};
		repeat (3) @(posedge i_clk);
		frame(1'b1);
		send(1'b1, 8'h00, 1'b1, 1'b1, 1'b0, 2'b00);
		idle();
		check(takes == 2, "add timed slots");
		check(mfs == 1, "multiframe mark");
		rd(4'h2, 16'h0010);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{i_arst_n, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = 0;
		{drun, dspe, dmark, dflip, arun, aspe, amark, dbyte} = 0;
		{i_add_timing_select, i_trib_byte, cfg} = {1'b1, 8'h5a, 5'h00};
		repeat (10) @(posedge i_clk);
		i_arst_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		rd(4'h0, 16'h0000);
		rd(4'h1, 16'h1c00);
		rd(4'h9, 16'h0000);
		drop_parity();
		rd(4'h3, 16'h0002);
		add_drop_timed();
		add_own_timed();
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
